// >>> common/spo_cfg_if.sv
interface spo_cfg_if;
    logic [15:0] options;
    logic [4:0] mode;
    logic [15:0] format;
    modport src (output options, output mode, output format);
    modport dst (input options, input mode, input format);
endinterface : spo_cfg_if

// >>> common/spo_pkg.sv
// Function
// - stop setting 0 one, 1 two bits
// - mode codes 1..18 decoded, 17 reserved
// - option 1 picks block check or crc
// - option 2 picks echo for terminal modes
// - option 2 native mode 205,X table routing
// - option 3 picks cr or cr/lf highlight
// - option 4 clear ends on control chars
// - option 5 native mode route replacement
// - option 6 peer mode and on-network status
// - option 7 gates tx driver by cts
// - option 8 mutes receiver while transmitting
// - option 9 disables remote master
// - option 9 clears slave bid buffer
// - option 9 intercepts read of 8188
// - intercepted reply: id low, bit14, run bit15
// - options 10 and 9 redirect via pointer
// - all option bits reset cleared
// - baud codes 0..15, code 13 9600
// - data setting 0 seven, 1 eight bits
// - parity 0 none, 1 odd, 2 even
package spo_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] off_options = 4'h0;
    localparam logic [3:0] off_pointer = 4'h1;
    localparam logic [3:0] off_format = 4'h2;
    localparam logic [3:0] off_mode = 4'h3;
    localparam logic [3:0] off_status = 4'h4;
    localparam logic [3:0] off_query = 4'h5;
    localparam logic [3:0] off_answer = 4'h6;
    localparam logic [15:0] options_reset = 16'h0000;
    localparam logic [15:0] pointer_reset = 16'h0000;
    localparam logic [15:0] options_used_mask = 16'h03ff;
    // ----------------------------------------
    // option bit positions (option bit n sits at index n-1)
    // ----------------------------------------
    localparam int opt_crc = 0;
    localparam int opt_echo = 1;
    localparam int opt_crlf = 2;
    localparam int opt_time_only = 3;
    localparam int opt_route_repl = 4;
    localparam int opt_peer = 5;
    localparam int opt_multidrop = 6;
    localparam int opt_half_duplex = 7;
    localparam int opt_nine = 8;
    localparam int opt_pointer = 9;
    // ----------------------------------------
    // format register fields
    // ----------------------------------------
    localparam int fmt_baud_lsb = 0;
    localparam int fmt_data_bit = 4;
    localparam int fmt_parity_lsb = 5;
    localparam int fmt_stop_bit = 7;
    localparam logic [15:0] format_reset = 16'h001d;
    localparam logic [4:0] mode_reset = 5'h01;
    // ----------------------------------------
    // protocol personalities
    // ----------------------------------------
    localparam logic [4:0] md_native = 5'h01;
    localparam logic [4:0] md_network_to_network_mode = 5'h02;
    localparam logic [4:0] md_peripheral = 5'h03;
    localparam logic [4:0] md_transparent = 5'h04;
    localparam logic [4:0] md_share = 5'h05;
    localparam logic [4:0] md_power_monitor = 5'h06;
    localparam logic [4:0] md_relay_ctl = 5'h07;
    localparam logic [4:0] md_gateway = 5'h08;
    localparam logic [4:0] md_multidrop = 5'h09;
    localparam logic [4:0] md_reg_host = 5'h0a;
    localparam logic [4:0] md_peer_net = 5'h0b;
    localparam logic [4:0] md_remote_master = 5'h0c;
    localparam logic [4:0] md_remote_slave = 5'h0d;
    localparam logic [4:0] md_reg_gate = 5'h0e;
    localparam logic [4:0] md_transfer = 5'h0f;
    localparam logic [4:0] md_refinery = 5'h10;
    localparam logic [4:0] md_reserved = 5'h11;
    localparam logic [4:0] md_reg_ascii = 5'h12;
    // ----------------------------------------
    // online-check interception
    // ----------------------------------------
    localparam logic [15:0] probe_reg = 16'd8188;
    localparam logic [7:0] report_id_opcode = 8'd17;
    localparam int ans_xlat_bit = 14;
    localparam int ans_run_bit = 15;
    localparam logic [7:0] route_table_drop = 8'd205;
    // ----------------------------------------
    // baud rates times ten, divided down from 100 MHz to a 16x oversample tick
    // ----------------------------------------
    localparam int clk_hz = 100000000;
    localparam int baud_x10 [16] = '{500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
                                     18000, 24000, 36000, 48000, 72000, 96000, 144000, 192000};
endpackage : spo_pkg

// >>> design/spo_baud_gen.sv
module spo_baud_gen (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] baud_code,
    output logic tick
);
    // ----------------------------------------
    // divider
    // ----------------------------------------
    function automatic logic [23:0] div_of(input logic [3:0] code);
        div_of = 24'((64'(spo_pkg::clk_hz) * 10) / (64'(spo_pkg::baud_x10[code]) * 16));
    endfunction : div_of

    logic [23:0] cnt_q;
    logic [3:0] code_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= 24'h000000;
            code_q <= 4'h0;
            tick <= 1'b0;
        end else begin
            code_q <= baud_code;
            // restart on a rate change so no stale long count lingers
            if (code_q != baud_code || cnt_q >= div_of(baud_code) - 24'h000001) begin
                cnt_q <= 24'h000000;
                tick <= (code_q == baud_code);
            end else begin
                cnt_q <= cnt_q + 24'h000001;
                tick <= 1'b0;
            end
        end
    end
endmodule : spo_baud_gen

// >>> design/spo_frame_fmt.sv
module spo_frame_fmt (
    input wire logic mclk,
    input wire logic rst,
    spo_cfg_if.dst cfg,
    output logic [3:0] char_bits,
    output logic parity_en,
    output logic parity_odd,
    output logic [1:0] stop_bits
);
    logic [1:0] par;
    assign par = cfg.format[spo_pkg::fmt_parity_lsb +: 2];

    always_ff @(posedge mclk) begin
        if (rst) begin
            char_bits <= 4'h8;
            parity_en <= 1'b0;
            parity_odd <= 1'b0;
            stop_bits <= 2'h1;
        end else begin
            char_bits <= cfg.format[spo_pkg::fmt_data_bit] ? 4'h8 : 4'h7;
            parity_en <= (par == 2'h1) || (par == 2'h2);
            parity_odd <= (par == 2'h1);
            stop_bits <= cfg.format[spo_pkg::fmt_stop_bit] ? 2'h2 : 2'h1;
        end
    end
endmodule : spo_frame_fmt

// >>> design/spo_port_ctl.sv
module spo_port_ctl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic cts,
    input wire logic transmitting,
    input wire logic remote_running,
    input wire logic [7:0] remote_slave_id,
    output logic tx_drive_en,
    output logic rx_enable,
    output logic baud_tick,
    output logic [3:0] char_bits,
    output logic parity_en,
    output logic parity_odd,
    output logic [1:0] stop_bits,
    output logic use_crc,
    output logic echo_en,
    output logic table_route_en,
    output logic reply_crlf,
    output logic ctrl_char_term,
    output logic route_replace_en,
    output logic peer_mode,
    output logic on_network,
    output logic master_active,
    output logic slave_buf_clear,
    output logic mode_valid
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] options_q;
    logic [15:0] pointer_q;
    logic [15:0] format_q;
    logic [4:0] mode_q;
    logic [15:0] query_q;
    logic [15:0] answer_q;
    logic [15:0] query_d;

    spo_cfg_if cfg_bus ();
    assign cfg_bus.options = options_q;
    assign cfg_bus.mode = mode_q;
    assign cfg_bus.format = format_q;

    function automatic logic is_mode(input logic [4:0] m, input logic [4:0] code);
        is_mode = (m == code);
    endfunction : is_mode

    always_ff @(posedge mclk) begin
        if (rst) begin
            options_q <= spo_pkg::options_reset;
            pointer_q <= spo_pkg::pointer_reset;
            format_q <= spo_pkg::format_reset;
            mode_q <= spo_pkg::mode_reset;
        end else if (wr) begin
            case (addr)
                spo_pkg::off_options: options_q <= wdata & spo_pkg::options_used_mask;
                spo_pkg::off_pointer: pointer_q <= wdata;
                spo_pkg::off_format: format_q <= wdata;
                spo_pkg::off_mode: mode_q <= wdata[4:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // one-hot personality flags
    logic m_native, m_n2n, m_multi, m_gate, m_trans, m_share, m_host, m_rmaster, m_rslave;
    assign m_native = is_mode(mode_q, spo_pkg::md_native);
    assign m_n2n = is_mode(mode_q, spo_pkg::md_network_to_network_mode);
    assign m_multi = is_mode(mode_q, spo_pkg::md_multidrop);
    assign m_gate = is_mode(mode_q, spo_pkg::md_gateway);
    assign m_trans = is_mode(mode_q, spo_pkg::md_transparent);
    assign m_share = is_mode(mode_q, spo_pkg::md_share);
    assign m_host = is_mode(mode_q, spo_pkg::md_reg_host);
    assign m_rmaster = is_mode(mode_q, spo_pkg::md_remote_master);
    assign m_rslave = is_mode(mode_q, spo_pkg::md_remote_slave);

    logic term_mode;
    assign term_mode = m_gate | m_trans | m_share;

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_valid <= 1'b1;
            use_crc <= 1'b0;
            echo_en <= 1'b0;
            table_route_en <= 1'b0;
            reply_crlf <= 1'b0;
            ctrl_char_term <= 1'b0;
            route_replace_en <= 1'b0;
            peer_mode <= 1'b0;
            on_network <= 1'b0;
            master_active <= 1'b0;
            slave_buf_clear <= 1'b0;
        end else begin
            mode_valid <= (mode_q >= spo_pkg::md_native) && (mode_q <= spo_pkg::md_reg_ascii)
                && (mode_q != spo_pkg::md_reserved);
            use_crc <= (m_native | m_n2n | m_multi) & options_q[spo_pkg::opt_crc];
            echo_en <= term_mode & options_q[spo_pkg::opt_echo];
            table_route_en <= m_native & options_q[spo_pkg::opt_echo];
            reply_crlf <= m_gate & options_q[spo_pkg::opt_crlf];
            ctrl_char_term <= term_mode & ~options_q[spo_pkg::opt_time_only];
            route_replace_en <= m_native & options_q[spo_pkg::opt_route_repl];
            peer_mode <= options_q[spo_pkg::opt_peer];
            on_network <= options_q[spo_pkg::opt_peer];
            master_active <= m_rmaster & ~options_q[spo_pkg::opt_nine];
            slave_buf_clear <= m_rslave & options_q[spo_pkg::opt_nine];
        end
    end

    // ----------------------------------------
    // line drivers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_drive_en <= 1'b1;
            rx_enable <= 1'b1;
        end else begin
            tx_drive_en <= ~options_q[spo_pkg::opt_multidrop] | cts;
            rx_enable <= ~(options_q[spo_pkg::opt_half_duplex] & transmitting);
        end
    end

    // ----------------------------------------
    // online-check probe: software writes a register number, reads the rewrite
    // ----------------------------------------
    logic spoof_on, redirect_on, probe_hit;
    assign spoof_on = m_host & options_q[spo_pkg::opt_nine];
    assign redirect_on = spoof_on & options_q[spo_pkg::opt_pointer];
    assign probe_hit = wr && (addr == spo_pkg::off_query) && (wdata == spo_pkg::probe_reg);

    always_comb begin
        query_d = query_q;
        if (wr && addr == spo_pkg::off_query) begin
            query_d = wdata;
            if (probe_hit && redirect_on) begin
                query_d = pointer_q;
            end else if (probe_hit && spoof_on) begin
                query_d = {8'h80, spo_pkg::report_id_opcode};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            query_q <= 16'h0000;
        end else begin
            query_q <= query_d;
        end
    end

    // answer tracks remote state; only meaningful after a translated probe
    always_ff @(posedge mclk) begin
        if (rst) begin
            answer_q <= 16'h0000;
        end else begin
            answer_q <= {remote_running, 1'b1, 6'h00, remote_slave_id};
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                spo_pkg::off_options: rdata <= options_q;
                spo_pkg::off_pointer: rdata <= pointer_q;
                spo_pkg::off_format: rdata <= format_q;
                spo_pkg::off_mode: rdata <= {11'h000, mode_q};
                spo_pkg::off_status: rdata <= {5'h00, mode_valid, master_active, slave_buf_clear,
                    on_network, peer_mode, route_replace_en, ctrl_char_term, reply_crlf,
                    table_route_en, echo_en, use_crc};
                spo_pkg::off_query: rdata <= query_q;
                spo_pkg::off_answer: rdata <= answer_q;
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ----------------------------------------
    // serial format helpers
    // ----------------------------------------
    spo_baud_gen u_baud (
        .mclk(mclk),
        .rst(rst),
        .baud_code(format_q[spo_pkg::fmt_baud_lsb +: 4]),
        .tick(baud_tick)
    );

    spo_frame_fmt u_fmt (
        .mclk(mclk),
        .rst(rst),
        .cfg(cfg_bus.dst),
        .char_bits(char_bits),
        .parity_en(parity_en),
        .parity_odd(parity_odd),
        .stop_bits(stop_bits)
    );
endmodule : spo_port_ctl

// >>> tb/serial_port_option_control_test.sv
module serial_port_option_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst, wr, rd, rd_d, cts, transmitting, run_cmd, remote_running, tx_drive_en, rx_enable;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, opt, fmt;
    logic [7:0] remote_slave_id;
    logic baud_tick;
    int gap;
    logic [4:0] md;
    logic [19:0] note;
    logic [19:0] exp_q[$];
    logic [15:0] qo[4] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300};
    logic [15:0] qe[4] = '{16'd8188, 16'h8011, 16'd8188, 16'h1234};
    int mismatches, total_checks;
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
    spo_port_ctl i_spo_port_ctl (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cts, .transmitting,
        .remote_running, .remote_slave_id, .tx_drive_en, .rx_enable, .baud_tick, .char_bits(),
        .parity_en(), .parity_odd(), .stop_bits(), .use_crc(), .echo_en(), .table_route_en(),
        .reply_crlf(), .ctrl_char_term(), .route_replace_en(), .peer_mode(), .on_network(),
        .master_active(), .slave_buf_clear(), .mode_valid());
    spo_far_dev i_spo_far_dev (.mclk, .run_cmd, .cts, .remote_running, .remote_slave_id);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------
    // bus tasks, one idle cycle after each strobe
    // ----------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back({a, e});
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
    endtask : rd_chk
    function automatic logic [15:0] stat(input logic [15:0] o, input logic [4:0] m);
        logic nat, term;
        nat = m == spo_pkg::md_native;
        term = m inside {spo_pkg::md_gateway, spo_pkg::md_share, spo_pkg::md_transparent};
        return {5'h00, m inside {[5'h01:5'h10], 5'h12}, m == spo_pkg::md_remote_master && !o[8],
            m == spo_pkg::md_remote_slave && o[8], o[5], o[5], nat && o[4], term && !o[3],
            m == spo_pkg::md_gateway && o[2], nat && o[1], term && o[1],
            o[0] && m inside {spo_pkg::md_native, spo_pkg::md_network_to_network_mode, spo_pkg::md_multidrop}};
    endfunction : stat
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        if (rd_d) begin
            note = exp_q.pop_front();
            `CHK($sformatf("reg %0h", note[19:16]), note[15:0], rdata)
        end
        rd_d <= rd;
    end
    initial begin
        #100us;
        mismatches++;
        $display("watchdog expired");
        summarize();
    end
    initial begin
        {rst, wr, rd, rd_d, transmitting, run_cmd, addr, wdata} = {6'h20, 4'h0, 16'h0000};
        void'($urandom(76096));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(spo_pkg::off_options, spo_pkg::options_reset);
        rd_chk(spo_pkg::off_format, spo_pkg::format_reset);
        rd_chk(spo_pkg::off_status, stat(16'h0000, spo_pkg::mode_reset));
        wr_reg(4'hf, 16'hffff);
        rd_chk(4'hf, 16'h0000);
        // reset format selects 9600 baud, ticks at sixteen times that rate
        @(posedge mclk iff baud_tick);
        gap = 0;
        do begin
            @(posedge mclk);
            gap++;
        end while (!baud_tick);
        `CHK("baud gap", spo_pkg::clk_hz / (9600 * 16), gap)
        $display("test reset done");
        for (int i = 0; i < 26; i++) begin
            md = (i < 20) ? 5'(i) : 5'($urandom);
            opt = 16'($urandom);
            fmt = {8'h00, 1'($urandom), 2'($urandom_range(2)), 5'($urandom)};
            wr_reg(spo_pkg::off_mode, {11'h000, md});
            wr_reg(spo_pkg::off_options, opt);
            wr_reg(spo_pkg::off_format, fmt);
            rd_chk(spo_pkg::off_options, opt & spo_pkg::options_used_mask);
            rd_chk(spo_pkg::off_status, stat(opt, md));
        end
        // redundant master held off
        wr_reg(spo_pkg::off_mode, {11'h000, spo_pkg::md_remote_master});
        wr_reg(spo_pkg::off_options, 16'h0000);
        rd_chk(spo_pkg::off_status, stat(16'h0000, spo_pkg::md_remote_master));
        wr_reg(spo_pkg::off_options, 16'h0100);
        rd_chk(spo_pkg::off_status, stat(16'h0100, spo_pkg::md_remote_master));
        wr_reg(spo_pkg::off_mode, {11'h000, spo_pkg::md_remote_slave});
        rd_chk(spo_pkg::off_status, stat(16'h0100, spo_pkg::md_remote_slave));
        $display("test decode done");
        wr_reg(spo_pkg::off_mode, {11'h000, spo_pkg::md_reg_host});
        wr_reg(spo_pkg::off_pointer, 16'h1234);
        for (int k = 0; k < 4; k++) begin
            wr_reg(spo_pkg::off_options, qo[k]);
            wr_reg(spo_pkg::off_query, 16'd8188);
            rd_chk(spo_pkg::off_query, qe[k]);
            wr_reg(spo_pkg::off_query, 16'd8187);
            rd_chk(spo_pkg::off_query, 16'd8187);
        end
        for (int k = 0; k < 2; k++) begin
            run_cmd <= k[0];
            repeat (3) @(posedge mclk);
            rd_chk(spo_pkg::off_answer, {k[0], 1'b1, 6'h00, remote_slave_id});
        end
        $display("test query done");
        for (int k = 0; k < 2; k++) begin
            wr_reg(spo_pkg::off_options, k[0] ? 16'h00c0 : 16'h0000);
            repeat (150) begin
                transmitting <= 1'($urandom);
                @(posedge mclk);
            end
        end
        $display("test gating done");
        wr_reg(spo_pkg::off_options, 16'h03ff);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(spo_pkg::off_options, 16'h0000);
        repeat (2) @(posedge mclk);
        $display("test rerun reset done");
        summarize();
    end
endmodule : serial_port_option_control_test
bind spo_port_ctl spo_chk i_spo_chk (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cts, .transmitting,
    .tx_drive_en, .rx_enable, .char_bits, .parity_en, .parity_odd, .stop_bits, .ctrl_char_term,
    .master_active, .slave_buf_clear);

// >>> tb/spo_far_dev.sv
module spo_far_dev (
    input wire logic mclk,
    input wire logic run_cmd,
    output logic cts,
    output logic remote_running,
    output logic [7:0] remote_slave_id
);
    timeunit 1ns;
    timeprecision 100ps;
    parameter logic [7:0] slave_id = 8'h5a;
    initial cts = 1'b0;
    initial remote_running = 1'b0;
    assign remote_slave_id = slave_id;
    // bus grant comes and goes as other drops take their turn
    always @(posedge mclk) begin
        cts <= 1'($urandom);
        remote_running <= run_cmd;
    end
endmodule : spo_far_dev

// >>> tb/spo_port_ctl_chk.sv
module spo_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic cts,
    input wire logic transmitting,
    input wire logic tx_drive_en,
    input wire logic rx_enable,
    input wire logic [3:0] char_bits,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic [1:0] stop_bits,
    input wire logic ctrl_char_term,
    input wire logic master_active,
    input wire logic slave_buf_clear
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] opt_q;
    // mirror of the options register, lagging outputs compare against it
    always_ff @(posedge mclk) begin
        if (rst) opt_q <= 16'h0000;
        else if (wr && addr == spo_pkg::off_options) opt_q <= wdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_stop_map: assert property (wr && addr == spo_pkg::off_format |->
        ##2 stop_bits == ($past(wdata[7], 2) ? 2'h2 : 2'h1)) else $error("stop bits wrong");
    a_data_map: assert property (wr && addr == spo_pkg::off_format |->
        ##2 char_bits == ($past(wdata[4], 2) ? 4'h8 : 4'h7)) else $error("data bits wrong");
    a_parity_map: assert property (wr && addr == spo_pkg::off_format |-> ##2
        parity_en == ($past(wdata[6:5], 2) != 2'h0) && parity_odd == ($past(wdata[6:5], 2) == 2'h1))
        else $error("parity wrong");
    // a reset edge forces both line drivers on, whatever the options held before
    a_tx_gate: assert property (tx_drive_en == ($past(rst) || !($past(opt_q[6]) && !$past(cts))))
        else $error("tx driver gating wrong");
    a_rx_gate: assert property (rx_enable == ($past(rst) || !($past(opt_q[7]) && $past(transmitting))))
        else $error("receiver gating wrong");
    a_master_off: assert property (master_active |-> !$past(opt_q[8]))
        else $error("master active while disabled");
    a_slave_clr: assert property (slave_buf_clear |-> $past(opt_q[8]))
        else $error("buffer clear without option");
    a_ctrl_term: assert property (ctrl_char_term |-> !$past(opt_q[3]))
        else $error("control char end while time only");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("read data not idle");
    a_resv_read: assert property ($past(rd) && $past(addr) == spo_pkg::off_options |->
        rdata[15:10] == 6'h00) else $error("reserved option bits read back");
    c_tx_float: cover property (!tx_drive_en);
    c_master: cover property (master_active);
    c_rx_mute: cover property (!rx_enable);
endmodule : spo_chk
